// File: logic/pecc_cfg.svh
// Purpose: offsets, field positions, reset values and limits of the
//          port error capture control block
// Assumes: bit numbers equal the field bit numbers of the registers
// Notes:   definitions only
`ifndef PECC_CFG_SVH
`define PECC_CFG_SVH

// ==========================================================
// register byte offsets
`define PECC_OFF_RATE_EN      16'h10c4
`define PECC_OFF_ATTR         16'h10c8
`define PECC_OFF_INJECT       16'h10e0
`define PECC_OFF_RATE_CNT     16'h10e4
`define PECC_OFF_W            16

// ==========================================================
// rate enable / error detect bit positions
`define PECC_B_VENDOR         0
`define PECC_B_SYM_CRC        9
`define PECC_B_SYM_BAD_ID     10
`define PECC_B_SYM_REJECT     11
`define PECC_B_PKT_BAD_ACKID  12
`define PECC_B_PKT_CRC        13
`define PECC_B_PKT_OVERSIZE   14
`define PECC_B_LR_BAD_ACKID   26
`define PECC_B_PROTOCOL       27
`define PECC_B_DELINEATION    29
`define PECC_B_UNEXP_ACK      30
`define PECC_B_LINK_TIMEOUT   31

// writable bits of the rate enable register
`define PECC_RATE_EN_MASK     32'hec007e01
`define PECC_RATE_EN_RESET    32'h00000000

// ==========================================================
// capture attributes fields
`define PECC_INFO_LSB         0
`define PECC_INFO_MSB         1
`define PECC_ETYPE_LSB        3
`define PECC_ETYPE_MSB        7
`define PECC_VALID_BIT        31
`define PECC_ATTR_MASK        32'h800000fb
`define PECC_ATTR_RESET       32'h00000000

// info type codes
`define PECC_INFO_PACKET      2'h0
`define PECC_INFO_SYMBOL      2'h1
`define PECC_INFO_VENDOR      2'h2

// packet length limit in bytes
`define PECC_PKT_MAX_BYTES    9'h114

// error classes
`define PECC_PACKET_BITS      32'h00007000
`define PECC_SYMBOL_BITS      32'h6c000e00
`define PECC_CAPTURE_BITS     32'h6c007e01

`endif

// File: logic/pecc_error_capture.sv
// Purpose: rate enable mask and capture attributes registers of one
//          serial port, with error qualification and capture locking
// Assumes: error inputs come from logic on clk, one-cycle pulses
// Notes:   apb slave answers in the first access cycle
//          map: 10c4 rate enable, 10c8 capture attributes,
//          10e0 detect inject (write only), 10e4 rate count
//          capture takes the lowest numbered enabled error on a bit not injected that cycle; link
//          timeout is counted but never captured
//          while capture valid is set no new error is loaded; a
//          software write of zero unlocks the capture registers
//          a hardware capture beats a software write in one cycle
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "pecc_cfg.svh"

module pecc_error_capture #(
  parameter int CNT_W = 16
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    ce,
  input  wire pecc_pkg::pecc_apb_req_s apbReq,
  output logic                         pready,
  output logic                         pslverr,
  output logic [31:0]                  prdata,
  input  wire logic                    debugMode,
  input  wire pecc_pkg::pecc_word_t    errDetect,
  input  wire pecc_pkg::pecc_pkt_len_s pktLen,
  output logic [5:0]                   rateIncCount,
  output logic                         captureLoad,
  output logic [31:0]                  captureSelect,
  output logic                         captureSymbolOnly,
  output logic                         captureLocked
);
  import pecc_pkg::*;

  // ==========================================================
  // registers and internal nets
  pecc_bus_e        busState_r;
  logic             pready_r;
  logic             pslverr_r;
  logic [31:0]      prdata_r;
  logic [31:0]      rateEn_r;
  logic [31:0]      attr_r;
  logic [CNT_W-1:0] rateCnt_r;
  logic [5:0]       rateInc_r;
  logic             capLoad_r;
  logic [31:0]      capSel_r;
  logic             capSym_r;
  logic             capLocked_r;

  logic             setupCyc;
  logic             wrDone;
  logic             hitRateEn;
  logic             hitAttr;
  logic             hitInject;
  logic             hitCnt;
  logic             mapped;
  logic [31:0]      readWord;
  logic [31:0]      hwEvents;
  logic [31:0]      swEvents;
  logic [31:0]      countable;
  logic [31:0]      capturable;
  logic             oversize;
  logic [5:0]       popCount;
  logic             capFound;
  logic [4:0]       capBit;
  logic [4:0]       capCode;
  logic [1:0]       capInfo;
  logic [31:0]      capOneHot;
  logic             capTake;
  logic [31:0]      attrNew;
  logic [CNT_W-1:0] cntSum;
  logic [CNT_W:0]   cntWide;

  // ==========================================================
  // apb address decode
  assign setupCyc  = apbReq.psel && !apbReq.penable;
  assign wrDone    = apbReq.psel && apbReq.penable && pready_r &&
                     apbReq.pwrite && !pslverr_r;
  assign hitRateEn = apbReq.paddr == `PECC_OFF_RATE_EN;
  assign hitAttr   = apbReq.paddr == `PECC_OFF_ATTR;
  assign hitInject = apbReq.paddr == `PECC_OFF_INJECT;
  assign hitCnt    = apbReq.paddr == `PECC_OFF_RATE_CNT;
  assign mapped    = hitRateEn || hitAttr || hitInject || hitCnt;

  // reserved bits read as zero; debug mode shows all attribute bits
  always_comb begin
    readWord = 32'h00000000;
    if (hitRateEn) begin
      readWord = rateEn_r & `PECC_RATE_EN_MASK;
    end else if (hitAttr) begin
      if (debugMode) begin
        readWord = attr_r;
      end else begin
        readWord = attr_r & `PECC_ATTR_MASK;
      end
    end else if (hitCnt) begin
      readWord = 32'(rateCnt_r);
    end
  end

  // ==========================================================
  // apb handshake: answer in the first access cycle
  // a master that drops psel mid-access sends the slave idle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busState_r <= PECC_IDLE;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      prdata_r   <= 32'h00000000;
    end else if (ce) begin
      case (busState_r)
        PECC_IDLE: begin
          pready_r  <= 1'b0;
          pslverr_r <= 1'b0;
          if (setupCyc) begin
            busState_r <= PECC_ACCESS;
            pready_r   <= 1'b1;
            pslverr_r  <= !mapped;
            prdata_r   <= (!apbReq.pwrite && mapped) ? readWord
                                                     : 32'h00000000;
          end
        end
        PECC_ACCESS: begin
          if (apbReq.psel && apbReq.penable) begin
            busState_r <= PECC_DONE;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
          end else if (!apbReq.psel) begin
            busState_r <= PECC_IDLE;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
          end
        end
        PECC_DONE: begin
          pready_r <= 1'b0;
          if (setupCyc) begin
            busState_r <= PECC_ACCESS;
            pready_r   <= 1'b1;
            pslverr_r  <= !mapped;
            prdata_r   <= (!apbReq.pwrite && mapped) ? readWord
                                                     : 32'h00000000;
          end else begin
            busState_r <= PECC_IDLE;
          end
        end
        default: begin
          busState_r <= PECC_IDLE;
          pready_r   <= 1'b0;
          pslverr_r  <= 1'b0;
        end
      endcase
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  // ==========================================================
  // rate enable mask register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rateEn_r <= `PECC_RATE_EN_RESET;
    end else if (ce && wrDone && hitRateEn) begin
      rateEn_r <= apbReq.pwdata & `PECC_RATE_EN_MASK;
    end
  end

  // ==========================================================
  // error qualification
  // only a packet with a valid length can be oversize
  assign oversize = pktLen.valid &&
                    (pktLen.lengthBytes > `PECC_PKT_MAX_BYTES);

  always_comb begin
    hwEvents = errDetect & `PECC_RATE_EN_MASK;
    hwEvents[`PECC_B_PKT_OVERSIZE] = errDetect[`PECC_B_PKT_OVERSIZE] ||
                                     oversize;
  end

  // software detect writes act as injected detections
  assign swEvents = (wrDone && hitInject) ?
                    (apbReq.pwdata & `PECC_RATE_EN_MASK) :
                    32'h00000000;

  // each enable bit gates its own error source
  always_comb begin
    countable = 32'h00000000;
    countable[`PECC_B_VENDOR] = hwEvents[`PECC_B_VENDOR] &&
                                rateEn_r[`PECC_B_VENDOR];
    countable[`PECC_B_SYM_CRC] = hwEvents[`PECC_B_SYM_CRC] &&
                                 rateEn_r[`PECC_B_SYM_CRC];
    countable[`PECC_B_SYM_BAD_ID] = hwEvents[`PECC_B_SYM_BAD_ID] &&
                                    rateEn_r[`PECC_B_SYM_BAD_ID];
    countable[`PECC_B_SYM_REJECT] = hwEvents[`PECC_B_SYM_REJECT] &&
                                    rateEn_r[`PECC_B_SYM_REJECT];
    countable[`PECC_B_PKT_BAD_ACKID] = hwEvents[`PECC_B_PKT_BAD_ACKID] &&
                                       rateEn_r[`PECC_B_PKT_BAD_ACKID];
    countable[`PECC_B_PKT_CRC] = hwEvents[`PECC_B_PKT_CRC] &&
                                 rateEn_r[`PECC_B_PKT_CRC];
    countable[`PECC_B_PKT_OVERSIZE] = hwEvents[`PECC_B_PKT_OVERSIZE] &&
                                      rateEn_r[`PECC_B_PKT_OVERSIZE];
    countable[`PECC_B_LR_BAD_ACKID] = hwEvents[`PECC_B_LR_BAD_ACKID] &&
                                      rateEn_r[`PECC_B_LR_BAD_ACKID];
    countable[`PECC_B_PROTOCOL] = hwEvents[`PECC_B_PROTOCOL] &&
                                  rateEn_r[`PECC_B_PROTOCOL];
    countable[`PECC_B_DELINEATION] = hwEvents[`PECC_B_DELINEATION] &&
                                     rateEn_r[`PECC_B_DELINEATION];
    countable[`PECC_B_UNEXP_ACK] = hwEvents[`PECC_B_UNEXP_ACK] &&
                                   rateEn_r[`PECC_B_UNEXP_ACK];
    countable[`PECC_B_LINK_TIMEOUT] = hwEvents[`PECC_B_LINK_TIMEOUT] &&
                                      rateEn_r[`PECC_B_LINK_TIMEOUT];
    countable = countable | (swEvents & rateEn_r);
  end

  // link timeout is counted but never captured
  assign capturable = countable & ~swEvents &
                      `PECC_CAPTURE_BITS;

  // enabled events this cycle, hardware and injected together
  always_comb begin
    popCount = 6'h00;
    for (int i = 0; i < 32; i++) begin
      popCount = popCount + {5'h00, countable[i]};
    end
  end

  // ==========================================================
  // capture selection: lowest numbered error wins
  always_comb begin
    capFound  = 1'b0;
    capBit    = 5'h00;
    capOneHot = 32'h00000000;
    for (int i = 31; i >= 0; i--) begin
      if (capturable[i]) begin
        capFound  = 1'b1;
        capBit    = 5'(i);
        capOneHot = 32'h00000001 << i;
      end
    end
  end

  // code is bit number less one, bit 0 maps to zero
  assign capCode = (capBit == 5'h00) ? 5'h00 : capBit - 5'h01;

  always_comb begin
    if ((capOneHot & `PECC_PACKET_BITS) != 32'h00000000) begin
      capInfo = `PECC_INFO_PACKET;
    end else if ((capOneHot & `PECC_SYMBOL_BITS) != 32'h00000000) begin
      capInfo = `PECC_INFO_SYMBOL;
    end else begin
      capInfo = `PECC_INFO_VENDOR;
    end
  end

  // any lock, set by hardware or software, blocks new loads
  assign capTake = capFound && !attr_r[`PECC_VALID_BIT] &&
                   !debugMode;

  // ==========================================================
  // capture attributes register
  // software write first; a hardware capture then overrides it
  always_comb begin
    attrNew = attr_r;
    if (wrDone && hitAttr) begin
      if (debugMode) begin
        attrNew = apbReq.pwdata;
      end else if (attr_r[`PECC_VALID_BIT]) begin
        attrNew[`PECC_VALID_BIT] = apbReq.pwdata[`PECC_VALID_BIT];
      end else begin
        attrNew = (attr_r & ~`PECC_ATTR_MASK) |
                  (apbReq.pwdata & `PECC_ATTR_MASK);
      end
    end
    if (capTake) begin
      attrNew[`PECC_INFO_MSB:`PECC_INFO_LSB]   = capInfo;
      attrNew[`PECC_ETYPE_MSB:`PECC_ETYPE_LSB] = capCode;
      attrNew[`PECC_VALID_BIT]                 = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      attr_r <= `PECC_ATTR_RESET;
    end else if (ce) begin
      attr_r <= attrNew;
    end
  end

  // ==========================================================
  // capture data load strobe and lock state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      capLoad_r   <= 1'b0;
      capSel_r    <= 32'h00000000;
      capSym_r    <= 1'b0;
    end else if (ce) begin
      capLoad_r   <= capTake;
      if (capTake) begin
        capSel_r <= capOneHot;
        capSym_r <= capInfo == `PECC_INFO_SYMBOL;
      end
    end
  end

  // lock output mirrors the valid bit as it is stored
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      capLocked_r <= 1'b0;
    end else if (ce) begin
      capLocked_r <= attrNew[`PECC_VALID_BIT];
    end
  end

  assign captureLoad       = capLoad_r;
  assign captureSelect     = capSel_r;
  assign captureSymbolOnly = capSym_r;
  assign captureLocked     = capLocked_r;

  // ==========================================================
  // error rate increment and saturating event count
  assign cntWide = {1'b0, rateCnt_r} + {{(CNT_W-5){1'b0}}, popCount};
  assign cntSum  = cntWide[CNT_W] ? {CNT_W{1'b1}} : cntWide[CNT_W-1:0];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rateInc_r <= 6'h00;
    end else if (ce) begin
      rateInc_r <= popCount;
    end
  end

  // a write to the count register restarts it from this cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rateCnt_r <= '0;
    end else if (ce) begin
      if (wrDone && hitCnt) begin
        rateCnt_r <= {{(CNT_W-6){1'b0}}, popCount};
      end else begin
        rateCnt_r <= cntSum;
      end
    end
  end

  assign rateIncCount = rateInc_r;

endmodule

// File: logic/pecc_pkg.sv
// Purpose: shared types of the port error capture control block
// Assumes: apb with 32-bit data
// Notes:   constants live in pecc_cfg.svh
package pecc_pkg;

  typedef logic [31:0] pecc_word_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } pecc_apb_req_s;

  typedef struct packed {
    logic        valid;
    logic [8:0]  lengthBytes;
  } pecc_pkt_len_s;

  typedef enum logic [2:0] {
    PECC_IDLE   = 3'b001,
    PECC_ACCESS = 3'b010,
    PECC_DONE   = 3'b100
  } pecc_bus_e;

endpackage

// File: verif/pecc_error_capture_chk.sv
// Purpose: port assertions of the error capture block
// Assumes: one clock domain, reset active high
// Notes:   bound to the design from the bench top file
`timescale 1ns/1ps
`include "pecc_cfg.svh"

module pecc_error_capture_chk #(
  parameter int CNT_W = 16
) (
  input wire logic                    clk,
  input wire logic                    reset,
  input wire logic                    ce,
  input wire pecc_pkg::pecc_apb_req_s apbReq,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic [31:0]             prdata,
  input wire logic                    debugMode,
  input wire pecc_pkg::pecc_word_t    errDetect,
  input wire pecc_pkg::pecc_pkt_len_s pktLen,
  input wire logic [5:0]              rateIncCount,
  input wire logic                    captureLoad,
  input wire logic [31:0]             captureSelect,
  input wire logic                    captureSymbolOnly,
  input wire logic                    captureLocked
);
  import pecc_pkg::*;
  logic setup;
  logic mapped;
  assign setup  = apbReq.psel && !apbReq.penable && ce;
  assign mapped = apbReq.paddr inside {`PECC_OFF_RATE_EN, `PECC_OFF_ATTR,
                                       `PECC_OFF_INJECT, `PECC_OFF_RATE_CNT};
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // register bus
  ready_after_setup_a: assert property (setup |=> pready)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  unmapped_error_a: assert property (
    setup |=> pslverr == !$past(mapped))
    else $error("error flag wrong for address");
  unmapped_zero_a: assert property (
    pready && pslverr && !apbReq.pwrite |-> prdata == '0)
    else $error("unmapped read not zero");
  // ==========================================================
  // capture and counting
  sequence quietS;
    (errDetect == '0 && !pktLen.valid && !apbReq.psel) [*3];
  endsequence
  capture_onehot_a: assert property (
    captureLoad |-> $onehot(captureSelect) &&
    (captureSelect & ~`PECC_CAPTURE_BITS) == '0)
    else $error("capture select not one capturable bit");
  capture_cause_a: assert property (
    captureLoad |-> (captureSelect & $past(errDetect)) != '0 ||
    (captureSelect[14] && $past(pktLen.valid)))
    else $error("capture without matching error");
  load_then_lock_a: assert property (captureLoad |-> captureLocked)
    else $error("capture did not lock");
  locked_no_load_a: assert property (captureLocked |=> !captureLoad)
    else $error("capture while locked");
  debug_no_load_a: assert property ($past(debugMode) |-> !captureLoad)
    else $error("capture in debug mode");
  symbol_flag_a: assert property (
    captureLoad |-> captureSymbolOnly ==
    |(captureSelect & `PECC_SYMBOL_BITS))
    else $error("symbol flag wrong");
  quiet_no_count_a: assert property (quietS |=> rateIncCount == '0)
    else $error("count without error");
endmodule

// File: verif/pecc_error_capture_tb_top.sv
// Purpose: self-checking bench of the error capture block
// Assumes: ce held high, debug mode set by one test only
// Notes:   an integer reference model predicts every result
`timescale 1ns/1ps
`include "pecc_cfg.svh"

module pecc_error_capture_tb_top;
  import pecc_pkg::*;
  localparam logic [15:0] EN = `PECC_OFF_RATE_EN;
  localparam logic [15:0] AT = `PECC_OFF_ATTR;
  localparam logic [15:0] IJ = `PECC_OFF_INJECT;
  localparam logic [15:0] CN = `PECC_OFF_RATE_CNT;
  logic          clk, reset, ce, debugMode;
  logic          pready, pslverr, captureLoad, captureSymbolOnly;
  logic          captureLocked;
  logic [31:0]   prdata, captureSelect, enM, attrM, rnd;
  logic [5:0]    rateIncCount;
  pecc_apb_req_s apbReq;
  pecc_word_t    errDetect;
  pecc_pkt_len_s pktLen;
  int            nMismatch, totalChecks, seed, sumSeen, sumExp;
  int            bits[12] = '{0, 9, 10, 11, 12, 13, 14, 26, 27, 29, 30, 31};
  int            lens[3] = '{276, 277, 511};
  logic [15:0]   adr[6] = '{EN, AT, IJ, CN, 16'h1000, 16'h10cc};

  pecc_error_capture #(.CNT_W(16)) u_pecc_error_capture (
    .clk(clk), .reset(reset), .ce(ce), .apbReq(apbReq), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .debugMode(debugMode),
    .errDetect(errDetect), .pktLen(pktLen), .rateIncCount(rateIncCount),
    .captureLoad(captureLoad), .captureSelect(captureSelect),
    .captureSymbolOnly(captureSymbolOnly), .captureLocked(captureLocked));

  always #5 clk = ~clk;
  always @(posedge clk) if (!reset) sumSeen <= sumSeen + rateIncCount;

  // ==========================================================
  // checking and bus tasks
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      nMismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic apb(bit w, logic [15:0] a, logic [31:0] d,
                     output logic [31:0] r, output logic er);
    int n;
    n = 0;
    @(posedge clk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    er = pslverr;
    apbReq <= '0;
    if (pready !== 1'b1) begin
      nMismatch++;
      end_sim();
    end
  endtask

  task automatic wr(logic [15:0] a, logic [31:0] d);
    logic [31:0] r;
    logic        er;
    apb(1'b1, a, d, r, er);
    if (a == EN) enM = d & `PECC_RATE_EN_MASK;
    if (a == IJ) sumExp += $countones(d & enM & `PECC_RATE_EN_MASK);
    if (a == AT && debugMode) attrM = d;
    else if (a == AT && attrM[31]) attrM[31] = d[31];
    else if (a == AT) attrM = d & `PECC_ATTR_MASK;
  endtask

  task automatic rd(logic [15:0] a);
    logic [31:0] r, e;
    logic        er;
    apb(1'b0, a, 32'h0, r, er);
    e = (a == EN) ? enM : (a == CN) ? (sumExp & 32'hffff) : 32'h0;
    if (a == AT) e = debugMode ? attrM : attrM & `PECC_ATTR_MASK;
    chk("rdata", e, r);
    chk("pslverr", {31'h0, !(a inside {EN, AT, IJ, CN})}, {31'h0, er});
  endtask

  task automatic hit(logic [31:0] e, logic [8:0] len, logic v);
    logic [31:0] q, sel;
    logic [1:0]  inf;
    int          n, et;
    @(posedge clk);
    errDetect <= e;
    pktLen <= '{v, len};
    @(posedge clk);
    errDetect <= '0;
    pktLen <= '0;
    q = e;
    q[14] = q[14] | (v && len > `PECC_PKT_MAX_BYTES);
    q = q & enM & `PECC_RATE_EN_MASK;
    sel = '0;
    n = 0;
    if ((q & `PECC_CAPTURE_BITS) != 0 && !attrM[31] && !debugMode) begin
      while (!q[n]) n++;
      sel[n] = 1'b1;
      et = (n == 0) ? 0 : n - 1;
      inf = (n == 0) ? 2'h2 : (n > 11 && n < 15) ? 2'h0 : 2'h1;
      attrM = {1'b1, 23'h0, et[4:0], 1'b0, inf};
    end
    sumExp += $countones(q);
    @(posedge clk);
    chk("count", $countones(q), {26'h0, rateIncCount});
    chk("load", {31'h0, sel != 0}, {31'h0, captureLoad});
    if (sel != 0) chk("select", sel, captureSelect);
    if (sel != 0)
      chk("symbol", {31'h0, inf == 2'h1}, {31'h0, captureSymbolOnly});
  endtask

  task automatic done(string nm);
    repeat (3) @(posedge clk);
    chk("sum", sumExp, sumSeen);
    if (!debugMode)
      chk("lock", {31'h0, attrM[31]}, {31'h0, captureLocked});
    $display("test %s done", nm);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clk = 0; reset = 1; ce = 1; debugMode = 0; apbReq = '0;
    errDetect = '0; pktLen = '0; nMismatch = 0; totalChecks = 0;
    sumSeen = 0; sumExp = 0; enM = 0; attrM = 0; seed = 32'h570f688f;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    foreach (adr[i]) rd(adr[i]);
    wr(EN, 32'hffffffff);
    rd(EN);
    done("reset");
    foreach (bits[i]) begin
      wr(EN, 32'h1 << bits[i]);
      hit(32'hffffffff, 9'h0, 1'b0);
      rd(AT);
      wr(AT, 32'h0);
      wr(EN, ~(32'h1 << bits[i]));
      hit(32'h1 << bits[i], 9'h0, 1'b0);
      wr(IJ, 32'hffffffff);
    end
    done("enables");
    wr(EN, 32'h4000);
    foreach (lens[i]) hit(32'h0, lens[i][8:0], 1'b1);
    rd(AT);
    wr(AT, 32'h0);
    wr(AT, 32'h80000000);
    wr(EN, 32'hffffffff);
    hit(32'h6c007e01, 9'h0, 1'b0);
    wr(AT, 32'h800000fb);
    rd(AT);
    wr(AT, 32'h0);
    hit(32'h6c007e00, 9'h0, 1'b0);
    rd(AT);
    done("lock");
    debugMode <= 1'b1;
    wr(AT, 32'h25c30f96);
    rd(AT);
    hit(32'h1, 9'h0, 1'b0);
    debugMode <= 1'b0;
    rd(AT);
    done("debug");
    repeat (40) begin
      wr(EN, $random(seed));
      rnd = $random(seed);
      hit($random(seed), rnd[8:0], rnd[9]);
      if (rnd[10]) wr(AT, $random(seed));
      rd(AT);
    end
    rd(CN);
    done("random");
    end_sim();
  end
endmodule

bind pecc_error_capture pecc_error_capture_chk #(.CNT_W(CNT_W)) u_chk (
  .clk(clk), .reset(reset), .ce(ce), .apbReq(apbReq), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .debugMode(debugMode),
  .errDetect(errDetect), .pktLen(pktLen), .rateIncCount(rateIncCount),
  .captureLoad(captureLoad), .captureSelect(captureSelect),
  .captureSymbolOnly(captureSymbolOnly), .captureLocked(captureLocked));
